// [hw/pcrp_params.sv]
// Read-only configuration bank with retry buffer and tag accounting
// ----------------------------------------------------------------
// Summary of operation
// RULE_01 - Device identifier fixed at build, writes ignored
// RULE_02 - Vendor identifier fixed, never all ones
// RULE_03 - Class code fixed, 24 bits, read only
// RULE_04 - Revision identifier fixed, 8 bits, read only
// RULE_05 - Subsystem device identifier fixed, read only
// RULE_06 - Subsystem vendor identifier fixed, never all ones
// RULE_07 - Slot clock bit shows common clock choice
// RULE_08 - ECRC check capable only with AER
// RULE_09 - ECRC generation capable only with AER
// RULE_10 - Link port number fixed, 8 bits
// RULE_11 - Outstanding tags limited to power-of-two count
// RULE_12 - MSI multiple message field encodes request count
// RULE_13 - MSI 64-bit flag; native endpoint forces it
// RULE_14 - Max payload supported field encodes build limit
// RULE_15 - One to four VCs, count reported
// RULE_16 - VCs below low count are low priority
// RULE_17 - Retry buffer holds packets until acknowledged
// RULE_18 - Retry buffer packet count never exceeds maximum
// RULE_19 - Auto sizing derives retry size from payload
// RULE_20 - Without AER both ECRC bits read zero
// ----------------------------------------------------------------
module pcrp_params #(
  parameter logic [15:0] DEVICE_IDENTIFIER = 16'h0001,    // Arbitrary value
  parameter logic [15:0] VENDOR_IDENTIFIER = 16'h0002,    // Arbitrary value
  parameter logic [23:0] CLASS_CODE = 24'h000000,
  parameter logic [7:0] SILICON_REVISION = 8'h01,      // Arbitrary value
  parameter logic [15:0] SUBSYS_ID = 16'h0003,    // Arbitrary value
  parameter logic [15:0] SUBSYS_VENDOR_IDENTIFIER = 16'h0004, // Arbitrary value
  parameter bit LINK_COMMON_CLK = 1'b1,
  parameter bit AER_EN = 1'b1,
  parameter bit ECRC_CHECK_EN = 1'b1,
  parameter bit ECRC_GEN_EN = 1'b1,
  parameter logic [7:0] PORT_NUMBER = 8'h01,
  parameter int TAGS_SUPPORTED = 32,
  parameter int MSI_MESSAGES = 1,
  parameter bit MSI_64BIT = 1'b1,
  parameter bit NATIVE_ENDPOINT = 1'b1,
  parameter int MAX_PAYLOAD = 256,
  parameter int NUM_VC = 1,
  parameter int NUM_LOW_VC = 0,
  parameter bit RETRY_AUTO = 1'b1,
  parameter int RETRY_BYTES = 4096,
  parameter int RETRY_MAX_PKTS = 64
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [pcrp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pcrp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pcrp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic tx_req,
  input wire logic [pcrp_pkg::LEN_W-1:0] tx_len,
  output logic tx_grant,
  output logic tx_refuse,
  input wire logic ack_valid,
  input wire logic [pcrp_pkg::LEN_W-1:0] ack_len,
  input wire logic tag_req,
  input wire logic tag_release,
  output logic tag_grant,
  output logic retry_full,
  output logic [pcrp_pkg::VC_MAX-1:0] vc_low_prio
);
  import pcrp_pkg::*;

  // ----------------------------------------------------------------
  // Derived build constants
  // ----------------------------------------------------------------
  localparam int MPS_LOG2 = $clog2(MAX_PAYLOAD);
  localparam int AUTO_LOG2 = (MPS_LOG2 + RTY_AUTO_SHIFT > RTY_LOG2_MAX) ?
                             RTY_LOG2_MAX : MPS_LOG2 + RTY_AUTO_SHIFT;
  localparam int RTY_LOG2 = RETRY_AUTO ? AUTO_LOG2 : $clog2(RETRY_BYTES); // RULE_19
  localparam logic [BYTE_W-1:0] RTY_SIZE = BYTE_W'(1 << RTY_LOG2);
  localparam logic [CNT_W-1:0] RTY_PKTS = CNT_W'(RETRY_MAX_PKTS);
  localparam logic [CNT_W-1:0] TAG_MAX = CNT_W'(TAGS_SUPPORTED);
  localparam logic [2:0] MPS_CODE = 3'(MPS_LOG2 - MPS_LOG2_MIN);
  localparam logic [2:0] MMC_CODE = 3'($clog2(MSI_MESSAGES));
  localparam logic [3:0] TAG_LOG2 = 4'($clog2(TAGS_SUPPORTED));
  localparam logic [2:0] VC_EXT = 3'(NUM_VC - 1);
  localparam logic [2:0] LOW_VC = 3'(NUM_LOW_VC);
  localparam logic [4:0] RTY_CODE = 5'(RTY_LOG2);
  localparam logic [3:0] PKT_CODE = 4'($clog2(RETRY_MAX_PKTS));
  localparam bit ECRC_CHK = AER_EN & ECRC_CHECK_EN; // RULE_08 RULE_20
  localparam bit ECRC_GEN = AER_EN & ECRC_GEN_EN;   // RULE_09 RULE_20
  localparam bit MSI64 = MSI_64BIT | NATIVE_ENDPOINT; // RULE_13

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic pause;
    logic [CNT_W-1:0] pkt_cnt;
    logic [BYTE_W-1:0] byte_cnt;
    logic [CNT_W-1:0] tag_cnt;
    logic tx_grant;
    logic tx_refuse;
    logic tag_grant;
    logic retry_full;
    logic [VC_MAX-1:0] vc_low;
  } pcrp_state_type;

  pcrp_state_type st_q;
  pcrp_state_type st_d;

  // Read decode; unmapped offsets answer zero
  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] a,
    input pcrp_state_type s
  );
    logic [DATA_W-1:0] w;
    w = '0;
    case (a)
      OFS_IDENT: begin
        w = {DEVICE_IDENTIFIER, VENDOR_IDENTIFIER}; // RULE_01 RULE_02
      end
      OFS_CLASS_REV: begin
        w = {CLASS_CODE, SILICON_REVISION}; // RULE_03 RULE_04
      end
      OFS_SUBSYS: begin
        w = {SUBSYS_ID, SUBSYS_VENDOR_IDENTIFIER}; // RULE_05 RULE_06
      end
      OFS_LINK: begin
        w[7:0] = PORT_NUMBER; // RULE_10
        w[POS_SLOT_CLK] = LINK_COMMON_CLK; // RULE_07
      end
      OFS_AER: begin
        w[POS_ECRC_GEN] = ECRC_GEN; // RULE_09
        w[POS_ECRC_CHK] = ECRC_CHK; // RULE_08
      end
      OFS_DEVCAP: begin
        w[2:0] = MPS_CODE; // RULE_14
        w[POS_TAGS +: 4] = TAG_LOG2; // RULE_11
      end
      OFS_MSI: begin
        w[POS_MMC +: 3] = MMC_CODE; // RULE_12
        w[POS_MSI64] = MSI64; // RULE_13
      end
      OFS_PVC1: begin
        w[2:0] = VC_EXT; // RULE_15
        w[POS_LOWVC +: 3] = LOW_VC; // RULE_16
      end
      OFS_RETRY: begin
        w[4:0] = RTY_CODE;
        w[POS_RTY_PKT +: 4] = PKT_CODE;
        w[POS_RTY_AUTO] = RETRY_AUTO;
      end
      OFS_CTRL: begin
        w[POS_PAUSE] = s.pause;
      end
      OFS_OCCUPY: begin
        w[CNT_W-1:0] = s.pkt_cnt;
        w[POS_TAG_CNT +: CNT_W] = s.tag_cnt;
      end
      OFS_BYTES: begin
        w[BYTE_W-1:0] = s.byte_cnt;
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Accept and acknowledge may land together; both are applied
  always_comb begin
    logic accept;
    logic room;
    logic [BYTE_W-1:0] need;
    logic [CNT_W-1:0] pk;
    logic [BYTE_W-1:0] by;
    logic [CNT_W-1:0] tg;
    accept = 1'b0;
    room = 1'b0;
    need = '0;
    pk = '0;
    by = '0;
    tg = '0;
    st_d = st_q;
    st_d.rdata = reg_rd ? read_word(reg_addr, st_q) : '0;
    // Only the pause bit is writable; identity words ignore writes
    if (reg_wr && reg_addr == OFS_CTRL) begin
      st_d.pause = reg_wdata[POS_PAUSE];
    end
    // Packet admission: both byte and packet room must hold
    need = st_q.byte_cnt + BYTE_W'(tx_len);
    room = (st_q.pkt_cnt < RTY_PKTS) && (need <= RTY_SIZE); // RULE_17 RULE_18
    accept = tx_req && room && !st_q.pause;
    st_d.tx_grant = accept;
    st_d.tx_refuse = tx_req && !accept;
    pk = st_q.pkt_cnt;
    by = st_q.byte_cnt;
    if (accept) begin
      pk = pk + CNT_W'(1);
      by = need;
    end
    // Storage is released only by acknowledgement; counts saturate at zero
    if (ack_valid && pk != '0) begin
      pk = pk - CNT_W'(1); // RULE_17
      by = (by >= BYTE_W'(ack_len)) ? by - BYTE_W'(ack_len) : '0;
    end
    st_d.pkt_cnt = pk;
    st_d.byte_cnt = by;
    st_d.retry_full = (pk >= RTY_PKTS); // RULE_18
    // Tag pool for non-posted requests
    tg = st_q.tag_cnt;
    st_d.tag_grant = tag_req && (tg < TAG_MAX); // RULE_11
    if (st_d.tag_grant) begin
      tg = tg + CNT_W'(1);
    end
    if (tag_release && tg != '0) begin
      tg = tg - CNT_W'(1);
    end
    st_d.tag_cnt = tg;
    // Priority grouping of implemented channels
    for (int i = 0; i < VC_MAX; i++) begin
      st_d.vc_low[i] = (i < NUM_LOW_VC) && (i < NUM_VC); // RULE_15 RULE_16
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset clears all counters and outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = st_q.rdata;
  assign tx_grant = st_q.tx_grant;
  assign tx_refuse = st_q.tx_refuse;
  assign tag_grant = st_q.tag_grant;
  assign retry_full = st_q.retry_full;
  assign vc_low_prio = st_q.vc_low;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_rd(logic [ADDR_W-1:0] a);
    reg_rd && reg_addr == a;
  endsequence

  property p_devid;
    s_rd(OFS_IDENT) |=> reg_rdata[31:POS_HI16] == DEVICE_IDENTIFIER;
  endproperty
  a_devid: assert property (p_devid) else $error("device_identifier wrong"); // RULE_01

  property p_vendor;
    s_rd(OFS_IDENT) |=> reg_rdata[15:0] == VENDOR_IDENTIFIER && reg_rdata[15:0] != ALL_ONES16;
  endproperty
  a_vendor: assert property (p_vendor) else $error("vendor_identifier bad"); // RULE_02

  property p_classrev;
    s_rd(OFS_CLASS_REV) |=> reg_rdata == {CLASS_CODE, SILICON_REVISION};
  endproperty
  a_classrev: assert property (p_classrev) else $error("class or revision wrong"); // RULE_03

  property p_subsys;
    s_rd(OFS_SUBSYS) |=> reg_rdata == {SUBSYS_ID, SUBSYS_VENDOR_IDENTIFIER}
      && reg_rdata[15:0] != ALL_ONES16;
  endproperty
  a_subsys: assert property (p_subsys) else $error("subsystem ids bad"); // RULE_06

  property p_link;
    s_rd(OFS_LINK) |=> reg_rdata[7:0] == PORT_NUMBER
      && reg_rdata[POS_SLOT_CLK] == LINK_COMMON_CLK;
  endproperty
  a_link: assert property (p_link) else $error("link capability wrong"); // RULE_10

  property p_aer;
    s_rd(OFS_AER) |=> (reg_rdata[POS_ECRC_CHK] == (AER_EN & ECRC_CHECK_EN))
      && (AER_EN || reg_rdata[POS_ECRC_GEN] == 1'b0);
  endproperty
  a_aer: assert property (p_aer) else $error("ecrc bits wrong"); // RULE_20

  property p_msi;
    s_rd(OFS_MSI) |=> reg_rdata[POS_MMC +: 3] == MMC_CODE
      && (!NATIVE_ENDPOINT || reg_rdata[POS_MSI64]);
  endproperty
  a_msi: assert property (p_msi) else $error("msi control wrong"); // RULE_13

  property p_pkts;
    st_q.pkt_cnt <= RTY_PKTS && st_q.byte_cnt <= RTY_SIZE;
  endproperty
  a_pkts: assert property (p_pkts) else $error("retry buffer overfilled"); // RULE_18

  property p_grant;
    tx_req && !st_q.pause && st_q.pkt_cnt == '0 && !ack_valid
      && BYTE_W'(tx_len) <= RTY_SIZE |=> tx_grant ##1 st_q.pkt_cnt != '0 || $past(ack_valid);
  endproperty
  a_grant: assert property (p_grant) else $error("packet not admitted"); // RULE_17

  property p_tags;
    st_q.tag_cnt == TAG_MAX && tag_req |=> !tag_grant;
  endproperty
  a_tags: assert property (p_tags) else $error("tag pool exceeded"); // RULE_11

  property p_vc;
    !$past(sys_rst) |-> vc_low_prio[0] == (NUM_LOW_VC > 0);
  endproperty
  a_vc: assert property (p_vc) else $error("vc priority wrong"); // RULE_16

  property p_mps;
    s_rd(OFS_DEVCAP) |=> reg_rdata[2:0] == MPS_CODE;
  endproperty
  a_mps: assert property (p_mps) else $error("payload field wrong"); // RULE_14

  // Write strobe aimed at one offset
  sequence s_wr(logic [ADDR_W-1:0] a);
    reg_wr && reg_addr == a;
  endsequence

  property p_wr_ident;
    s_wr(OFS_IDENT) ##[1:2] s_rd(OFS_IDENT) |=> reg_rdata == {DEVICE_IDENTIFIER, VENDOR_IDENTIFIER};
  endproperty
  a_wr_ident: assert property (p_wr_ident) else $error("identity changed by write"); // RULE_01

  property p_rd_idle;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read"); // RULE_01

  property p_slot;
    s_rd(OFS_LINK) |=> reg_rdata[POS_SLOT_CLK] == LINK_COMMON_CLK;
  endproperty
  a_slot: assert property (p_slot) else $error("slot clock bit wrong"); // RULE_07

  property p_ecrc_chk;
    s_rd(OFS_AER) |=> reg_rdata[POS_ECRC_CHK] == (AER_EN && ECRC_CHECK_EN);
  endproperty
  a_ecrc_chk: assert property (p_ecrc_chk) else $error("ecrc check bit wrong"); // RULE_08

  property p_ecrc_gen;
    s_rd(OFS_AER) |=> reg_rdata[POS_ECRC_GEN] == (AER_EN && ECRC_GEN_EN);
  endproperty
  a_ecrc_gen: assert property (p_ecrc_gen) else $error("ecrc gen bit wrong"); // RULE_09

  property p_tag_ok;
    tag_req && st_q.tag_cnt < TAG_MAX |=> tag_grant;
  endproperty
  a_tag_ok: assert property (p_tag_ok) else $error("free tag refused"); // RULE_11

  property p_tag_cnt;
    st_q.tag_cnt <= TAG_MAX;
  endproperty
  a_tag_cnt: assert property (p_tag_cnt) else $error("tags over limit"); // RULE_11

  property p_vcount;
    s_rd(OFS_PVC1) |=> reg_rdata[2:0] == 3'(NUM_VC - 1)
      && reg_rdata[POS_LOWVC +: 3] == 3'(NUM_LOW_VC);
  endproperty
  a_vcount: assert property (p_vcount) else $error("vc counts wrong"); // RULE_15

  property p_pause;
    tx_req && st_q.pause |=> tx_refuse && !tx_grant;
  endproperty
  a_pause: assert property (p_pause) else $error("packet taken while paused"); // RULE_17

  property p_hold;
    !ack_valid && !tx_req |=> $stable(st_q.pkt_cnt) && $stable(st_q.byte_cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("storage freed without ack"); // RULE_17

  property p_nospace;
    tx_req && st_q.pkt_cnt == RTY_PKTS |=> tx_refuse && !tx_grant;
  endproperty
  a_nospace: assert property (p_nospace) else $error("packet taken when full"); // RULE_18

  property p_full;
    retry_full == (st_q.pkt_cnt == RTY_PKTS);
  endproperty
  a_full: assert property (p_full) else $error("full flag wrong"); // RULE_18

  property p_retry_size;
    s_rd(OFS_RETRY) |=> reg_rdata[POS_RTY_AUTO] == RETRY_AUTO
      && (!RETRY_AUTO || reg_rdata[4:0] == 5'(AUTO_LOG2));
  endproperty
  a_retry_size: assert property (p_retry_size) else $error("retry size wrong"); // RULE_19
endmodule

// [hw/pcrp_pkg.sv]
// Package: register map, field positions and limits of the read-only parameter bank
package pcrp_pkg;
  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LEN_W = 12;
  localparam int CNT_W = 9;
  localparam int BYTE_W = 16;
  localparam int VC_MAX = 4;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_IDENT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CLASS_REV = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SUBSYS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LINK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_AER = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DEVCAP = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MSI = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PVC1 = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_RETRY = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_OCCUPY = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_BYTES = 8'h2C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_HI16 = 16;
  localparam int POS_CLASS = 8;
  localparam int POS_SLOT_CLK = 8;
  localparam int POS_ECRC_GEN = 5;
  localparam int POS_ECRC_CHK = 7;
  localparam int POS_TAGS = 8;
  localparam int POS_MMC = 1;
  localparam int POS_MSI64 = 7;
  localparam int POS_LOWVC = 4;
  localparam int POS_RTY_PKT = 8;
  localparam int POS_RTY_AUTO = 16;
  localparam int POS_TAG_CNT = 16;
  localparam int POS_PAUSE = 0;
  // ----------------------------------------------------------------
  // Limits
  // ----------------------------------------------------------------
  localparam int MPS_LOG2_MIN = 7;
  localparam int RTY_LOG2_MAX = 14;
  localparam int RTY_AUTO_SHIFT = 2;
  localparam logic [15:0] ALL_ONES16 = 16'hFFFF;
endpackage

// [tb/pcrp_link_model.sv]
// Far-side model: acknowledges accepted packets oldest first
module pcrp_link_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hold,
  input wire logic tx_req,
  input wire logic [pcrp_pkg::LEN_W-1:0] tx_len,
  input wire logic tx_grant,
  output logic ack_valid,
  output logic [pcrp_pkg::LEN_W-1:0] ack_len,
  output logic idle
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcrp_pkg::*;
  logic [LEN_W-1:0] pend[$];
  logic [LEN_W-1:0] len_q;
  // ----------------------------------------------------------------
  // Acknowledge engine
  // ----------------------------------------------------------------
  // Hold stalls acks so the bench can fill the retry buffer
  always @(posedge clk) begin
    if (sys_rst) begin
      pend.delete();
      ack_valid <= 1'b0;
      ack_len <= '0;
      len_q <= '0;
      idle <= 1'b1;
    end else begin
      if (tx_grant) pend.push_back(len_q);
      if (tx_req) len_q <= tx_len;
      if (!hold && !ack_valid && pend.size() > 0) begin
        ack_valid <= 1'b1;
        ack_len <= pend.pop_front();
      end else begin
        ack_valid <= 1'b0;
        ack_len <= ~ack_len; // Released line toggles each idle cycle between the last length and its inverse
      end
      idle <= (pend.size() == 0);
    end
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the read-only parameter bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pcrp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tx_req = 1'b0, tag_req = 1'b0, tag_release = 1'b0;
  logic hold = 1'b1;
  logic [LEN_W-1:0] tx_len = '0, ack_len;
  logic [DATA_W-1:0] rdata_a, rdata_b, a, b;
  logic ack_valid, tx_grant, tx_refuse, tag_grant, retry_full, idle;
  logic [VC_MAX-1:0] vc_low_prio;
  int failures = 0;
  int num_checks = 0;
  // Build choices of the two instances; the expected words below follow from them
  localparam logic [15:0] A_DEVICE_IDENTIFIER = 16'h1A2B;
  localparam logic [15:0] A_VENDOR_IDENTIFIER = 16'h3C4D;
  localparam logic [23:0] A_CLASS_CODE = 24'h123456;
  localparam logic [7:0] A_SILICON_REVISION = 8'h5E;
  localparam logic [15:0] A_SUBSYS_ID = 16'h6F70;
  localparam logic [15:0] A_SUBSYS_VENDOR_IDENTIFIER = 16'h8192;
  localparam bit A_COMMON_CLK = 1'b0;
  localparam bit A_AER_EN = 1'b1;
  localparam bit A_ECRC_CHK = 1'b1;
  localparam bit A_ECRC_GEN = 1'b0;
  localparam logic [7:0] A_PORT_NUMBER = 8'hA5;
  localparam int A_TAGS = 4;
  localparam int A_MSI_MSGS = 8;
  localparam bit A_MSI_64BIT = 1'b0;
  localparam bit A_NATIVE = 1'b0;
  localparam int A_MAX_PAYLOAD = 256;
  localparam int A_NUM_VC = 3;
  localparam int A_NUM_LOW_VC = 2;
  localparam bit A_RETRY_AUTO = 1'b0;
  localparam int A_RETRY_BYTES = 512;
  localparam int A_RETRY_PKTS = 4;
  localparam bit B_AER_EN = 1'b0;
  localparam bit B_ECRC_CHK = 1'b1;
  localparam bit B_ECRC_GEN = 1'b1;
  localparam bit B_COMMON_CLK = 1'b1;
  localparam bit B_MSI_64BIT = 1'b0;
  localparam bit B_NATIVE = 1'b1;
  localparam int B_MSI_MSGS = 32;
  localparam int B_TAGS = 256;
  localparam int B_MAX_PAYLOAD = 2048;
  localparam bit B_RETRY_AUTO = 1'b1;
  // ----------------------------------------------------------------
  // Clock, devices and far side
  // ----------------------------------------------------------------
  initial forever #50 clk = ~clk;
  pcrp_params #(.DEVICE_IDENTIFIER(A_DEVICE_IDENTIFIER), .VENDOR_IDENTIFIER(A_VENDOR_IDENTIFIER),
    .CLASS_CODE(A_CLASS_CODE), .SILICON_REVISION(A_SILICON_REVISION), .SUBSYS_ID(A_SUBSYS_ID),
    .SUBSYS_VENDOR_IDENTIFIER(A_SUBSYS_VENDOR_IDENTIFIER), .LINK_COMMON_CLK(A_COMMON_CLK),
    .AER_EN(A_AER_EN), .ECRC_CHECK_EN(A_ECRC_CHK), .ECRC_GEN_EN(A_ECRC_GEN),
    .PORT_NUMBER(A_PORT_NUMBER), .TAGS_SUPPORTED(A_TAGS), .MSI_MESSAGES(A_MSI_MSGS),
    .MSI_64BIT(A_MSI_64BIT), .NATIVE_ENDPOINT(A_NATIVE), .MAX_PAYLOAD(A_MAX_PAYLOAD),
    .NUM_VC(A_NUM_VC), .NUM_LOW_VC(A_NUM_LOW_VC), .RETRY_AUTO(A_RETRY_AUTO),
    .RETRY_BYTES(A_RETRY_BYTES), .RETRY_MAX_PKTS(A_RETRY_PKTS)) pcrp_params_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_a), .tx_req(tx_req),
    .tx_len(tx_len), .tx_grant(tx_grant), .tx_refuse(tx_refuse), .ack_valid(ack_valid),
    .ack_len(ack_len), .tag_req(tag_req), .tag_release(tag_release),
    .tag_grant(tag_grant), .retry_full(retry_full), .vc_low_prio(vc_low_prio));
  // Second build: no error reporting, native endpoint, automatic retry sizing
  pcrp_params #(.AER_EN(B_AER_EN), .ECRC_CHECK_EN(B_ECRC_CHK), .ECRC_GEN_EN(B_ECRC_GEN),
    .LINK_COMMON_CLK(B_COMMON_CLK), .MSI_64BIT(B_MSI_64BIT), .NATIVE_ENDPOINT(B_NATIVE),
    .MSI_MESSAGES(B_MSI_MSGS), .TAGS_SUPPORTED(B_TAGS), .MAX_PAYLOAD(B_MAX_PAYLOAD),
    .RETRY_AUTO(B_RETRY_AUTO)) pcrp_params_noaer_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_b), .tx_req(tx_req),
    .tx_len(tx_len), .tx_grant(), .tx_refuse(), .ack_valid(ack_valid),
    .ack_len(ack_len), .tag_req(tag_req), .tag_release(tag_release),
    .tag_grant(), .retry_full(), .vc_low_prio());
  pcrp_link_model pcrp_link_model_inst (.clk(clk), .sys_rst(sys_rst), .hold(hold),
    .tx_req(tx_req), .tx_len(tx_len), .tx_grant(tx_grant), .ack_valid(ack_valid),
    .ack_len(ack_len), .idle(idle));
  // ----------------------------------------------------------------
  // Bus cycles and compare
  // ----------------------------------------------------------------
  // Wide enough to judge both instances' words in one compare
  task check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data is looked at only in the cycle after the strobe
  task rd(input logic [ADDR_W-1:0] ad);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 a = rdata_a;
    b = rdata_b;
  endtask
  task wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task send(input logic [LEN_W-1:0] len, input logic ok);
    @(posedge clk);
    tx_req <= 1'b1;
    tx_len <= len;
    @(posedge clk);
    tx_req <= 1'b0;
    tx_len <= ~len;
    #1 check({tx_grant, tx_refuse}, {ok, !ok});
  endtask
  task tag(input logic req, input logic exp);
    @(posedge clk);
    tag_req <= req;
    tag_release <= !req;
    @(posedge clk);
    tag_req <= 1'b0;
    tag_release <= 1'b0;
    #1 if (req) check(tag_grant, exp);
  endtask
  // Bounded wait until the far side has acknowledged everything
  task drain();
    int n;
    hold <= 1'b0;
    repeat (2) @(posedge clk);
    for (n = 0; n < 60; n++) begin
      #1 if (idle === 1'b1 && ack_valid === 1'b0) break;
      @(posedge clk);
    end
    hold <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_ids();
    wr(OFS_CLASS_REV, 32'h0);
    wr(OFS_SUBSYS, 32'hFFFFFFFF);
    wr(OFS_IDENT, 32'hFFFFFFFF);
    rd(OFS_IDENT);
    check(a, 32'h1A2B3C4D);
    rd(OFS_CLASS_REV);
    check(a, 32'h1234565E);
    rd(OFS_SUBSYS);
    check(a, 32'h6F708192);
    $display("test ids done");
  endtask
  task t_caps();
    rd(OFS_LINK);
    check({a, b}, {32'h000000A5, 32'h00000101});
    rd(OFS_AER);
    check({a, b}, {32'h00000080, 32'h0});
    rd(OFS_DEVCAP);
    check({a, b}, {32'h00000201, 32'h00000804});
    rd(OFS_MSI);
    check({a, b}, {32'h00000006, 32'h0000008A});
    rd(OFS_PVC1);
    check({a, b}, {32'h00000022, 32'h0});
    check(vc_low_prio, 4'b0011);
    rd(OFS_RETRY);
    check({a, b}, {32'h00000209, 32'h0001060D});
    $display("test caps done");
  endtask
  task t_retry();
    send(12'd256, 1'b1);
    send(12'd256, 1'b1);
    send(12'd1, 1'b0);
    rd(OFS_BYTES);
    check(a, 32'd512);
    drain();
    rd(OFS_OCCUPY);
    check(a, 32'h0);
    repeat (4) send(12'd16, 1'b1);
    check(retry_full, 1'b1);
    send(12'd16, 1'b0);
    drain();
    check(retry_full, 1'b0);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL);
    check(a, 32'h1);
    send(12'd16, 1'b0);
    wr(OFS_CTRL, 32'h0);
    send(12'd16, 1'b1);
    drain();
    rd(8'h30);
    check(a, 32'h0);
    #100 check(rdata_a, 32'h0);
    $display("test retry done");
  endtask
  task t_tags();
    repeat (4) tag(1'b1, 1'b1);
    tag(1'b1, 1'b0);
    rd(OFS_OCCUPY);
    check(a, 32'h00040000);
    tag(1'b0, 1'b0);
    tag(1'b1, 1'b1);
    $display("test tags done");
  endtask
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Tests need well under a thousand cycles
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_ids();
    t_caps();
    t_retry();
    t_tags();
    give_verdict();
  end
endmodule
